// ===== common/fecs_defines.vh
// Constants for the flash command, protection and security sequencer
`ifndef FECS_DEFINES_VH
`define FECS_DEFINES_VH

// Register addresses on the plain register port
`define FECS_ADDR_STAT      4'h0
`define FECS_ADDR_INDEX     4'h1
`define FECS_ADDR_PROT      4'h2
`define FECS_ADDR_SEC       4'h3
`define FECS_ADDR_CMDWORD   4'h4
`define FECS_ADDR_KEY       4'h5
`define FECS_ADDR_MODE      4'h6
`define FECS_ADDR_PQUERY    4'h7

// Status register bit positions
`define FECS_STAT_COMMAND_COMPLETE_FLAG      7
`define FECS_STAT_ACCESS_ERROR_FLAG    5
`define FECS_STAT_PROTECTION_VIOLATION_FLAG    4
`define FECS_STAT_VERR      1
`define FECS_STAT_VUNC      0

// Protection register fields
`define FECS_PROT_OPEN      7
`define FECS_PROT_HDIS      5
`define FECS_PROT_HS_HI     4
`define FECS_PROT_HS_LO     3
`define FECS_PROT_LDIS      2
`define FECS_PROT_LS_HI     1
`define FECS_PROT_LS_LO     0

// Command codes
`define FECS_CMD_VERIFY_KEY 8'h0C
`define FECS_CMD_PROG_EE    8'h11
`define FECS_CMD_ERASE_SECT 8'h12

// Command word index limits
`define FECS_IDX_SECT       3'h1
`define FECS_IDX_PROG_MIN   3'h2
`define FECS_IDX_PROG_MAX   3'h5

// Security codes
`define FECS_SEC_UNSECURE   2'h2
`define FECS_SEC_SECURE     2'h1

// Address map, 18-bit global
`define FECS_EE_BASE        18'h00400
`define FECS_EE_LAST        18'h00BFF
`define FECS_PF_TOP         18'h3FFFF
`define FECS_PF_LOW_BASE    18'h38000
`define FECS_PF_HIGH_2K     18'h03800

// Default timing, cycles of clk_i, and config field address
`define FECS_ERASE_CYCLES   16'h0040
`define FECS_PROG_CYCLES    16'h0010
`define FECS_ADDR_CONFIG    18'h3FF0C

`endif

// ===== logic/fecs_top.v
// Flash command launch checks, sector erase, protection decode and backdoor unsecure
//Function
//- Program index outside 2..5 flags access error
//- Command not allowed in mode flags error
//- Invalid global address flags access error
//- Odd word address flags access error
//- Program run past EEPROM end flags error
//- Protected EEPROM target flags protection violation
//- Any verify error sets verify error flag
//- Uncorrectable verify error sets second flag
//- Erase sector, verify, then set complete
//- Erase index not exactly 1 flags error
//- High range size decodes 2..16 Kbytes
//- Low range size decodes 1..8 Kbytes
//- Protection loaded on first clock after reset release, software may change
//- Correct backdoor key forces security to 10
//- Wrong key locks out key verify until reset
//- Key verify leaves stored security, keys untouched
//- Key verify leaves protection register unchanged
//- Unsecured device may erase or program protected EEPROM
//- Security code 10 unsecured, others secured
//- Word index selects command array word
`timescale 1ns/1ps
`default_nettype none
`include "fecs_defines.vh"

module fecs_top #(
    parameter        SECT_BYTES  = 4,          // EEPROM sector size in bytes
    parameter [15:0] ERASE_CYC   = `FECS_ERASE_CYCLES,
    parameter [15:0] PROG_CYC    = `FECS_PROG_CYCLES,
    parameter [63:0] BACKDOOR_KEY = 64'h0123456789ABCDEF  // Arbitrary stand-in for stored key
) (
    input  wire        clk_i,           // System clock
    input  wire        reset_i,         // Async reset, active high
    input  wire        ce_i,            // Clock enable, freezes state when low
    input  wire [3:0]  addr_i,          // Register address
    input  wire [15:0] wdata_i,         // Write data
    input  wire        wr_i,            // Write strobe
    input  wire        rd_i,            // Read strobe
    output reg  [15:0] rdata_o,         // Read data, cycle after strobe
    input  wire [7:0]  cfg_prot_i,      // Protection byte from flash config field
    input  wire [1:0]  cfg_backdoor_key_enable_i,     // Backdoor enable bits from config field
    input  wire [1:0]  cfg_sec_i,       // Security bits from config field
    input  wire        verify_err_i,    // Array verify found an error
    input  wire        verify_unc_i,    // Array verify found an uncorrectable error
    output reg         array_busy_o,    // Array operation running
    output reg         array_erase_o,   // Erase pulse to array, one cycle per word
    output reg         array_prog_o,    // Program pulse to array
    output reg  [17:0] array_addr_o,    // Array word address
    output reg  [15:0] array_data_o,    // Array program data
    output reg         unsecured_o      // Device is unsecured or in special mode
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_RUN   = 2'h1;
    localparam ST_VFY   = 2'h2;

    // Erase walks the whole sector one word at a time, last word index
    localparam integer SECT_WM1 = SECT_BYTES / 2 - 1;

    reg [15:0] cmd_word_ff [0:7];      // Command object array
    reg [2:0]  command_word_index_ff;
    reg [7:0]  protection_register_ff;
    reg [1:0]  security_state_ff;
    reg [1:0]  backdoor_key_enable_ff;
    reg        cfg_loaded_ff;
    reg        key_locked_ff;
    reg        special_mode_ff;
    reg        command_complete_flag_ff;
    reg        access_error_flag_ff;
    reg        protection_violation_flag_ff;
    reg        verify_error_flag_ff;
    reg        verify_uncorrectable_flag_ff;
    reg [1:0]  state_ff;
    reg [15:0] cnt_ff;
    reg [17:0] op_addr_ff;
    reg [2:0]  op_words_ff;
    reg        op_erase_ff;
    reg [2:0]  data_sel_ff;
    reg [1:0]  vfy_dly_ff;
    reg        verr_s1_ff, verr_s2_ff, vunc_s1_ff, vunc_s2_ff;

    integer i;

    // Decoders for the two program-memory protection windows
    function in_high;
        input [17:0] a;
        input [1:0]  sz;
        begin
            in_high = (a >= (`FECS_PF_TOP - ((18'h00800 << sz) - 18'h00001)));
        end
    endfunction

    function in_low;
        input [17:0] a;
        input [1:0]  sz;
        begin
            in_low = (a >= `FECS_PF_LOW_BASE) &&
                     (a < (`FECS_PF_LOW_BASE + (18'h00400 << sz)));
        end
    endfunction

    // Protection scheme applied to a program-memory address
    function pf_protected;
        input [17:0] a;
        input [7:0]  p;
        reg          hi, lo;
        begin
            hi = !p[`FECS_PROT_HDIS] && in_high(a, p[`FECS_PROT_HS_HI:`FECS_PROT_HS_LO]);
            lo = !p[`FECS_PROT_LDIS] && in_low(a, p[`FECS_PROT_LS_HI:`FECS_PROT_LS_LO]);
            if (p[`FECS_PROT_OPEN])
                pf_protected = hi || lo;
            else
                pf_protected = !(hi || lo);
        end
    endfunction

    wire        is_unsec  = (security_state_ff == `FECS_SEC_UNSECURE);
    wire        key_en    = (backdoor_key_enable_ff == 2'h2);
    wire [7:0]  cmd_code  = cmd_word_ff[0][15:8];
    wire [17:0] gaddr     = {cmd_word_ff[0][1:0], cmd_word_ff[1]};
    wire [2:0]  nwords    = command_word_index_ff - 3'h1;
    wire [17:0] last_addr = gaddr + {14'h0000, nwords, 1'b0} - 18'h00002;
    wire        ee_valid  = (gaddr >= `FECS_EE_BASE) && (gaddr <= `FECS_EE_LAST);
    // EEPROM has no range scheme of its own here; protect nothing unless open bit low
    wire        ee_prot   = !protection_register_ff[`FECS_PROT_OPEN] &&
                            !is_unsec && !special_mode_ff;
    wire        is_prog   = (cmd_code == `FECS_CMD_PROG_EE);
    wire        is_erase  = (cmd_code == `FECS_CMD_ERASE_SECT);
    wire        is_key    = (cmd_code == `FECS_CMD_VERIFY_KEY);
    wire        key_ok    = ({cmd_word_ff[1], cmd_word_ff[2], cmd_word_ff[3], cmd_word_ff[4]}
                             == BACKDOOR_KEY);

    reg         acc_err;
    reg         prot_err;

    // Launch-time checks
    always @* begin
        acc_err  = 1'b0;
        prot_err = 1'b0;
        if (is_prog) begin
            if (command_word_index_ff < `FECS_IDX_PROG_MIN ||
                command_word_index_ff > `FECS_IDX_PROG_MAX)
                acc_err = 1'b1;
            if (!ee_valid)
                acc_err = 1'b1;
            if (gaddr[0])
                acc_err = 1'b1;
            if (last_addr > `FECS_EE_LAST)
                acc_err = 1'b1;
            prot_err = ee_prot;
        end else if (is_erase) begin
            if (command_word_index_ff != `FECS_IDX_SECT)
                acc_err = 1'b1;
            if (!ee_valid || gaddr[0])
                acc_err = 1'b1;
            prot_err = ee_prot;
        end else if (is_key) begin
            // Key verify only while secured in normal mode, enabled, not locked out
            if (!key_en || key_locked_ff || is_unsec || special_mode_ff ||
                command_word_index_ff != 3'h4)
                acc_err = 1'b1;
        end else begin
            acc_err = 1'b1;
        end
    end

    wire wr_stat  = wr_i && (addr_i == `FECS_ADDR_STAT);
    wire launch   = wr_stat && wdata_i[`FECS_STAT_COMMAND_COMPLETE_FLAG] && command_complete_flag_ff &&
                    state_ff == ST_IDLE;
    wire clr_err  = wr_stat;
    wire vfy_err  = (state_ff == ST_VFY) && verr_s2_ff;
    wire vfy_unc  = (state_ff == ST_VFY) && vunc_s2_ff;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (i = 0; i < 8; i = i + 1)
                cmd_word_ff[i] <= 16'h0000;
            command_word_index_ff        <= 3'h0;
            protection_register_ff       <= 8'hFF;
            security_state_ff            <= `FECS_SEC_SECURE;
            backdoor_key_enable_ff       <= 2'h0;
            cfg_loaded_ff                <= 1'b0;
            key_locked_ff                <= 1'b0;
            special_mode_ff              <= 1'b0;
            command_complete_flag_ff     <= 1'b1;
            access_error_flag_ff         <= 1'b0;
            protection_violation_flag_ff <= 1'b0;
            verify_error_flag_ff         <= 1'b0;
            verify_uncorrectable_flag_ff <= 1'b0;
            state_ff                     <= ST_IDLE;
            cnt_ff                       <= 16'h0000;
            op_addr_ff                   <= 18'h00000;
            op_words_ff                  <= 3'h0;
            op_erase_ff                  <= 1'b0;
            data_sel_ff                  <= 3'h0;
            vfy_dly_ff                   <= 2'h0;
            verr_s1_ff                   <= 1'b0;
            verr_s2_ff                   <= 1'b0;
            vunc_s1_ff                   <= 1'b0;
            vunc_s2_ff                   <= 1'b0;
            rdata_o                      <= 16'h0000;
            array_busy_o                 <= 1'b0;
            array_erase_o                <= 1'b0;
            array_prog_o                 <= 1'b0;
            array_addr_o                 <= 18'h00000;
            array_data_o                 <= 16'h0000;
            unsecured_o                  <= 1'b0;
        end else if (ce_i) begin
            // Verify results come from the array, outside this clock
            verr_s1_ff <= verify_err_i;
            verr_s2_ff <= verr_s1_ff;
            vunc_s1_ff <= verify_unc_i;
            vunc_s2_ff <= vunc_s1_ff;
            array_erase_o <= 1'b0;
            array_prog_o  <= 1'b0;

            // Config field captured once after release; software may override protection later
            if (!cfg_loaded_ff) begin
                cfg_loaded_ff          <= 1'b1;
                protection_register_ff <= cfg_prot_i;
                backdoor_key_enable_ff <= cfg_backdoor_key_enable_i;
                security_state_ff      <= cfg_sec_i;
            end else if (wr_i && addr_i == `FECS_ADDR_PROT && state_ff == ST_IDLE) begin
                protection_register_ff <= wdata_i[7:0];
            end

            if (wr_i && addr_i == `FECS_ADDR_INDEX)
                command_word_index_ff <= wdata_i[2:0];
            if (wr_i && addr_i == `FECS_ADDR_CMDWORD && command_complete_flag_ff)
                cmd_word_ff[command_word_index_ff] <= wdata_i;
            if (wr_i && addr_i == `FECS_ADDR_MODE)
                special_mode_ff <= wdata_i[0];

            if (rd_i) begin
                case (addr_i)
                    `FECS_ADDR_STAT:    rdata_o <= {8'h00, command_complete_flag_ff, 1'b0,
                                                    access_error_flag_ff,
                                                    protection_violation_flag_ff, 2'b00,
                                                    verify_error_flag_ff,
                                                    verify_uncorrectable_flag_ff};
                    `FECS_ADDR_INDEX:   rdata_o <= {13'h0000, command_word_index_ff};
                    `FECS_ADDR_PROT:    rdata_o <= {8'h00, protection_register_ff};
                    `FECS_ADDR_SEC:     rdata_o <= {10'h000, key_locked_ff, is_unsec,
                                                    backdoor_key_enable_ff, security_state_ff};
                    `FECS_ADDR_CMDWORD: rdata_o <= cmd_word_ff[command_word_index_ff];
                    `FECS_ADDR_MODE:    rdata_o <= {15'h0000, special_mode_ff};
                    // Probe of the range decode for the address held in words 0 and 1
                    `FECS_ADDR_PQUERY:  rdata_o <= {15'h0000,
                                                    pf_protected(gaddr, protection_register_ff)};
                    default:            rdata_o <= 16'h0000;
                endcase
            end

            // Error flags: writing one to a flag clears it, hardware set wins
            if (clr_err && wdata_i[`FECS_STAT_ACCESS_ERROR_FLAG])
                access_error_flag_ff <= 1'b0;
            if (clr_err && wdata_i[`FECS_STAT_PROTECTION_VIOLATION_FLAG])
                protection_violation_flag_ff <= 1'b0;

            case (state_ff)
                ST_IDLE: begin
                    if (launch) begin
                        verify_error_flag_ff         <= 1'b0;
                        verify_uncorrectable_flag_ff <= 1'b0;
                        if (acc_err || prot_err) begin
                            // Operation not started; completion stays set
                            access_error_flag_ff         <= acc_err;
                            protection_violation_flag_ff <= prot_err && !acc_err;
                            if (is_key && acc_err && key_en && !is_unsec)
                                key_locked_ff <= key_locked_ff;
                        end else if (is_key) begin
                            // Only security state or key lockout moves; stored bytes and protection stay
                            if (key_ok) begin
                                security_state_ff <= `FECS_SEC_UNSECURE;
                            end else begin
                                key_locked_ff <= 1'b1;
                            end
                        end else begin
                            command_complete_flag_ff <= 1'b0;
                            op_erase_ff   <= is_erase;
                            op_addr_ff    <= is_erase ?
                                             (gaddr & ~(SECT_BYTES[17:0] - 18'h00001)) : gaddr;
                            op_words_ff   <= is_erase ? SECT_WM1[2:0] : nwords - 3'h1;
                            data_sel_ff   <= 3'h2;
                            cnt_ff        <= is_erase ? ERASE_CYC : PROG_CYC;
                            array_busy_o  <= 1'b1;
                            state_ff      <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    array_addr_o <= op_addr_ff;
                    array_data_o <= cmd_word_ff[data_sel_ff];
                    if (cnt_ff == (op_erase_ff ? ERASE_CYC : PROG_CYC)) begin
                        array_erase_o <= op_erase_ff;
                        array_prog_o  <= !op_erase_ff;
                    end
                    if (cnt_ff == 16'h0001) begin
                        if (op_words_ff == 3'h0) begin
                            vfy_dly_ff <= 2'h3;
                            state_ff   <= ST_VFY;
                        end else begin
                            op_words_ff <= op_words_ff - 3'h1;
                            op_addr_ff  <= op_addr_ff + 18'h00002;
                            data_sel_ff <= data_sel_ff + 3'h1;
                            cnt_ff      <= op_erase_ff ? ERASE_CYC : PROG_CYC;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - 16'h0001;
                    end
                end
                ST_VFY: begin
                    // Let the synchronised verify result settle before finishing
                    if (vfy_err)
                        verify_error_flag_ff <= 1'b1;
                    if (vfy_unc)
                        verify_uncorrectable_flag_ff <= 1'b1;
                    if (vfy_dly_ff == 2'h0) begin
                        command_complete_flag_ff <= 1'b1;
                        array_busy_o <= 1'b0;
                        state_ff     <= ST_IDLE;
                    end else begin
                        vfy_dly_ff <= vfy_dly_ff - 2'h1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase

            unsecured_o <= is_unsec || special_mode_ff;
        end
    end

endmodule
`default_nettype wire

// ===== sim/fecs_top_asserts.sv
// Port-level assertions for the flash command, protection and security sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fecs_defines.vh"
module fecs_chk (
    input wire        clk_i,         // System clock
    input wire        reset_i,       // Async reset, active high
    input wire        ce_i,          // Clock enable
    input wire [3:0]  addr_i,        // Register address
    input wire [15:0] wdata_i,       // Write data
    input wire        wr_i,          // Write strobe
    input wire        rd_i,          // Read strobe
    input wire [15:0] rdata_o,       // Read data
    input wire [7:0]  cfg_prot_i,    // Protection config byte
    input wire [1:0]  cfg_backdoor_key_enable_i,   // Backdoor enable config
    input wire [1:0]  cfg_sec_i,     // Security config
    input wire        verify_err_i,  // Verify error
    input wire        verify_unc_i,  // Verify uncorrectable
    input wire        array_busy_o,  // Array busy
    input wire        array_erase_o, // Erase pulse
    input wire        array_prog_o,  // Program pulse
    input wire [17:0] array_addr_o,  // Array address
    input wire [15:0] array_data_o,  // Array data
    input wire        unsecured_o    // Unsecured state
);
    wire launch_w = ce_i && wr_i && addr_i == `FECS_ADDR_STAT && wdata_i[`FECS_STAT_COMMAND_COMPLETE_FLAG];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_op_start;
        $rose(array_busy_o);
    endsequence
    sequence s_op_end;
        ##[1:400] !array_busy_o;
    endsequence
    sequence s_pulse;
        array_erase_o ##1 !array_erase_o;
    endsequence
    // Busy only ever rises one or two cycles after a launch write
    a_busy_cause: assert property (s_op_start |-> $past(launch_w) || $past(launch_w, 2))
        else $error("busy rose without a launch");
    a_busy_bound: assert property (s_op_start |-> s_op_end)
        else $error("operation never completed");
    a_erase_once: assert property (array_erase_o |-> s_pulse)
        else $error("erase pulse longer than one cycle");
    a_erase_busy: assert property (array_erase_o |-> array_busy_o)
        else $error("erase pulse outside an operation");
    a_prog_busy: assert property (array_prog_o |-> array_busy_o && !array_erase_o)
        else $error("program pulse outside an operation");
    a_rdata_hold: assert property (!$past(rd_i) |-> $stable(rdata_o))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (ce_i && rd_i && addr_i == `FECS_ADDR_KEY |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_reset_load: assert property ($fell(reset_i) |-> ##3 unsecured_o == (cfg_sec_i == 2'h2))
        else $error("security not loaded from config");
endmodule
bind fecs_top fecs_chk i_chk (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cfg_prot_i(cfg_prot_i),
    .cfg_backdoor_key_enable_i(cfg_backdoor_key_enable_i), .cfg_sec_i(cfg_sec_i), .verify_err_i(verify_err_i),
    .verify_unc_i(verify_unc_i), .array_busy_o(array_busy_o), .array_erase_o(array_erase_o),
    .array_prog_o(array_prog_o), .array_addr_o(array_addr_o), .array_data_o(array_data_o),
    .unsecured_o(unsecured_o));
`default_nettype wire

// ===== sim/fecs_tb.sv
// Self-checking bench for the flash command, protection and security sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fecs_defines.vh"
module testbench;
    localparam logic [63:0] KEY = 64'h0123456789ABCDEF; // Arbitrary key value
    logic        clk_i, reset_i, ce_i, wr_i, rd_i, verify_err_i, verify_unc_i, rd_d1;
    logic [7:0]  cfg_prot;
    logic [1:0]  cfg_backdoor_key_enable, cfg_sec;
    logic [26:0] pq [5];
    logic [3:0]  addr_i;
    logic [15:0] wdata_i, d;
    logic [31:0] exp_q[$], e, seed_val;
    logic [17:0] ea_q[$];
    logic [58:0] cases [9];
    wire  [15:0] rdata_o, array_data_o;
    wire  [17:0] array_addr_o;
    wire         array_busy_o, array_erase_o, array_prog_o, unsecured_o;
    int          err_total, comparisons, prog_cnt;
    fecs_top #(.SECT_BYTES(4), .ERASE_CYC(16'h0004), .PROG_CYC(16'h0004), .BACKDOOR_KEY(KEY)) i_dut (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cfg_prot_i(cfg_prot), .cfg_backdoor_key_enable_i(cfg_backdoor_key_enable),
        .cfg_sec_i(cfg_sec), .verify_err_i(verify_err_i), .verify_unc_i(verify_unc_i),
        .array_busy_o(array_busy_o), .array_erase_o(array_erase_o), .array_prog_o(array_prog_o),
        .array_addr_o(array_addr_o), .array_data_o(array_data_o), .unsecured_o(unsecured_o));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Read data stands one cycle, so compare exactly two edges after the strobe
    always @(posedge clk_i) begin
        if (rd_d1) begin
            e = exp_q.pop_front();
            comparisons++;
            if ((rdata_o & e[31:16]) !== e[15:0]) begin
                err_total++;
                $display("BAD t=%0t got=%h exp=%h", $time, rdata_o & e[31:16], e[15:0]);
            end
        end
        rd_d1 <= rd_i;
        if (array_erase_o === 1'b1) ea_q.push_back(array_addr_o);
        if (array_prog_o === 1'b1) prog_cnt++;
    end
    task automatic print_verdict;
        $display("counts comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] v);
        exp_q.push_back({m, v & m});
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // Words 1..4 come from k; the index is left at last when launching
    task automatic cmd(input logic [15:0] w0, input logic [63:0] k, input logic [2:0] last);
        logic [127:0] all;
        int           n;
        all = {w0, k, 48'h0};
        for (int i = 0; i <= last; i++) begin
            wr(`FECS_ADDR_INDEX, i[15:0]);
            wr(`FECS_ADDR_CMDWORD, all[127-16*i -: 16]);
        end
        ea_q.delete();
        prog_cnt = 0;
        wr(`FECS_ADDR_STAT, 16'h0080);
        n = 0;
        repeat (3) @(posedge clk_i);
        while (array_busy_o !== 1'b0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 400, 1);
    endtask
    task automatic do_reset;
        reset_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial begin
        {reset_i, wr_i, rd_i, verify_err_i, verify_unc_i, rd_d1} = 6'h20;
        ce_i = 1'b1;
        cfg_prot = 8'hFF;
        cfg_backdoor_key_enable = 2'h2;
        cfg_sec = 2'h1;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        seed_val = $urandom(32'h720bd3e0);
        // Fields: w0, w1, index, protection byte, expected status
        cases = '{{16'h1200, 16'h0400, 3'h0, 8'hFF, 16'h00A0}, {16'h1200, 16'h0400, 3'h2, 8'hFF, 16'h00A0},
            {16'h1200, 16'h0401, 3'h1, 8'hFF, 16'h00A0}, {16'h1200, 16'h0000, 3'h1, 8'hFF, 16'h00A0},
            {16'h1100, 16'h0400, 3'h1, 8'hFF, 16'h00A0}, {16'h1100, 16'h0400, 3'h6, 8'hFF, 16'h00A0},
            {16'h1100, 16'h0BFE, 3'h3, 8'hFF, 16'h00A0}, {16'h1200, 16'h0400, 3'h1, 8'h7F, 16'h0090},
            {16'h1100, 16'h0BFC, 3'h3, 8'hFF, 16'h0080}};
        // Fields: protection byte, global address, expected protected bit
        pq = '{{8'h84, 18'h3F800, 1'b1}, {8'h84, 18'h3F7FE, 1'b0}, {8'hA3, 18'h39FFE, 1'b1},
            {8'hA3, 18'h3A000, 1'b0}, {8'h24, 18'h3F7FE, 1'b1}};
        do_reset();
        rd(`FECS_ADDR_STAT, 16'h00B3, 16'h0080);
        rd(`FECS_ADDR_PROT, 16'h00BF, 16'h00BF);
        rd(`FECS_ADDR_SEC, 16'h003F, 16'h0009);
        rd(`FECS_ADDR_KEY, 16'hFFFF, 16'h0000);
        chk(unsecured_o, 0);
        ce_i <= 1'b0;
        wr(`FECS_ADDR_INDEX, 16'h0005);
        ce_i <= 1'b1;
        rd(`FECS_ADDR_INDEX, 16'h0007, 16'h0000);
        wr(`FECS_ADDR_MODE, 16'h0001);
        rd(`FECS_ADDR_MODE, 16'h0001, 16'h0001);
        chk(unsecured_o, 1);
        wr(`FECS_ADDR_MODE, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            wr(`FECS_ADDR_INDEX, i[15:0]);
            wr(`FECS_ADDR_CMDWORD, d);
            rd(`FECS_ADDR_INDEX, 16'h0007, i[15:0]);
            rd(`FECS_ADDR_CMDWORD, 16'hFFFF, d);
        end
        $display("test word index done");
        for (int i = 0; i < 4; i++) begin
            verify_err_i <= i[0];
            verify_unc_i <= i[1];
            cmd(16'h1200, {16'h0402, 48'h0}, 3'h1);
            chk(ea_q.size(), 2);
            chk(ea_q[0], 18'h00400);
            chk(ea_q[1], 18'h00402);
            rd(`FECS_ADDR_STAT, 16'h00B3, {14'h0020, i[0], i[1]});
        end
        verify_err_i <= 1'b0;
        verify_unc_i <= 1'b0;
        $display("test sector erase done");
        foreach (cases[i]) begin
            wr(`FECS_ADDR_PROT, {8'h00, cases[i][23:16]});
            rd(`FECS_ADDR_PROT, 16'h00BF, {8'h00, cases[i][23:16]});
            cmd(cases[i][58:43], {cases[i][42:27], $urandom, 16'h0000}, cases[i][26:24]);
            chk(ea_q.size() + prog_cnt, (cases[i][15:0] == 16'h0080) ? 2 : 0);
            rd(`FECS_ADDR_STAT, 16'h00B0, cases[i][15:0]);
            wr(`FECS_ADDR_STAT, 16'h0030);
        end
        $display("test launch errors done");
        foreach (pq[i]) begin
            wr(`FECS_ADDR_PROT, {8'h00, pq[i][26:19]});
            wr(`FECS_ADDR_INDEX, 16'h0000);
            wr(`FECS_ADDR_CMDWORD, {14'h0000, pq[i][18:17]});
            wr(`FECS_ADDR_INDEX, 16'h0001);
            wr(`FECS_ADDR_CMDWORD, pq[i][16:1]);
            rd(`FECS_ADDR_PQUERY, 16'h0001, {15'h0000, pq[i][0]});
        end
        wr(`FECS_ADDR_PROT, 16'h00FF);
        $display("test protection ranges done");
        cmd({`FECS_CMD_VERIFY_KEY, 8'h00}, ~KEY, 3'h4);
        rd(`FECS_ADDR_SEC, 16'h003F, 16'h0029);
        cmd({`FECS_CMD_VERIFY_KEY, 8'h00}, KEY, 3'h4);
        chk(unsecured_o, 0);
        cfg_prot <= 8'hA3;
        do_reset();
        cmd({`FECS_CMD_VERIFY_KEY, 8'h00}, KEY, 3'h4);
        chk(unsecured_o, 1);
        rd(`FECS_ADDR_SEC, 16'h003F, 16'h001A);
        rd(`FECS_ADDR_PROT, 16'h00BF, 16'h00A3);
        wr(`FECS_ADDR_PROT, 16'h007F);
        cmd(16'h1200, {16'h0400, 48'h0}, 3'h1);
        chk(ea_q.size(), 2);
        rd(`FECS_ADDR_STAT, 16'h00B0, 16'h0080);
        repeat (4) @(posedge clk_i);
        $display("test backdoor key done");
        print_verdict();
    end
endmodule
`default_nettype wire
